// file: motion_irq_consts.svh
// register map, field positions, reset values and timing for the interrupt and output block
`ifndef MOTION_IRQ_CONSTS_SVH
`define MOTION_IRQ_CONSTS_SVH

`define ADDR_FRAME_SYNC_STATUS  7'h36
`define ADDR_PIN_CONFIG         7'h37
`define ADDR_WATERMARK_STATUS   7'h39
`define ADDR_IRQ_STATUS         7'h3A
`define ADDR_ACCEL_X_HIGH       7'h3B
`define ADDR_ACCEL_X_LOW        7'h3C
`define ADDR_ACCEL_Y_HIGH       7'h3D
`define ADDR_ACCEL_Y_LOW        7'h3E
`define ADDR_ACCEL_Z_HIGH       7'h3F
`define ADDR_ACCEL_Z_LOW        7'h40
`define ADDR_TEMPERATURE_HIGH   7'h41
`define ADDR_TEMPERATURE_LOW    7'h42
`define ADDR_RATE_X_HIGH        7'h43
`define ADDR_RATE_X_LOW         7'h44
`define ADDR_RATE_Y_HIGH        7'h45

`define CFG_ACTIVE_LOW_BIT      7
`define CFG_OPEN_DRAIN_BIT      6
`define CFG_LATCH_BIT           5
`define CFG_ANY_READ_CLEAR_BIT  4
`define CFG_FS_POLARITY_BIT     3
`define CFG_FS_IRQ_ENABLE_BIT   2
`define CFG_SECOND_PIN_BIT      0
`define CFG_WRITE_MASK          8'hFD
`define CFG_RESET               8'h00

`define STAT_MOTION_X_BIT       7
`define STAT_MOTION_Y_BIT       6
`define STAT_MOTION_Z_BIT       5
`define STAT_OVERFLOW_BIT       4
`define STAT_DRIVE_READY_BIT    2
`define STAT_DATA_READY_BIT     0
`define STAT_WATERMARK_BIT      6
`define STAT_FRAME_SYNC_BIT     7

`define FLAG_MOTION_X           0
`define FLAG_MOTION_Y           1
`define FLAG_MOTION_Z           2
`define FLAG_OVERFLOW           3
`define FLAG_DRIVE_READY        4
`define FLAG_DATA_READY         5
`define FLAG_WATERMARK          6
`define FLAG_FRAME_SYNC         7
`define FLAG_COUNT              8

`define BYTE_ZERO               8'h00
`define SAMPLE_RESET            16'h0000
`define THRESHOLD_DISABLED      10'h000
`define PULSE_WIDTH_NS          50000
`define CLK_PERIOD_NS           5

`endif

// file: motion_irq_pkg.sv
// shared types for the interrupt and output block
package motion_irq_pkg;
  typedef logic [7:0] reg_byte_type;
  typedef logic [6:0] reg_addr_type;
  typedef logic [15:0] sample_type;
  typedef enum logic [1:0] {IRQ_IDLE, IRQ_PULSE, IRQ_LATCH} irq_state_type;
endpackage : motion_irq_pkg

// file: pin_drive_if.sv
// level and output enable of one interrupt pin between driver and top
`timescale 1ns/1ps
`default_nettype none
interface pin_drive_if;
  logic level;
  logic oe;
  modport drv (output level, output oe);
  modport mon (input level, input oe);
endinterface : pin_drive_if
`default_nettype wire

// file: status_flag_cell.sv
// one sticky status flag, a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module status_flag_cell (
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  input  wire logic set_in,
  input  wire logic clear_in,
  output var  logic flag_out
);
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      flag_out <= 1'b0;
    end else begin
      flag_out <= set_in | (flag_out & ~clear_in);
    end
  end
endmodule : status_flag_cell
`default_nettype wire

// file: irq_pin_driver.sv
// polarity and drive type of one interrupt pin, registered
`timescale 1ns/1ps
`default_nettype none
module irq_pin_driver (
  input  wire logic  clk_sys_in,
  input  wire logic  rst_in,
  input  wire logic  assert_in,
  input  wire logic  active_low_in,
  input  wire logic  open_drain_in,
  input  wire logic  enable_in,
  pin_drive_if.drv   pin
);
  logic want_high;
  assign want_high = assert_in ^ active_low_in;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin.level <= 1'b0;
      pin.oe    <= 1'b0;
    end else if (!enable_in) begin
      pin.level <= 1'b0;
      pin.oe    <= 1'b0;
    end else if (open_drain_in) begin
      // open drain only pulls low, the board pulls high
      pin.level <= 1'b0;
      pin.oe    <= ~want_high;
    end else begin
      pin.level <= want_high;
      pin.oe    <= 1'b1;
    end
  end
endmodule : irq_pin_driver
`default_nettype wire

// file: motion_interrupt_and_output_regs.sv
// interrupt pin control, clear-on-read status and sample output registers
//
// What this block does
// - config bit 7 set makes the interrupt pin active low, else active high.
// - config bit 6 set gives open-drain pin drive, else push-pull.
// - config bit 5 set latches the pin until status clears, else 50 us pulse.
// - config bit 4 set lets any read clear status, else only status reads.
// - config bit 3 set makes frame-sync input active low, else active high.
// - config bit 2 set lets frame-sync reaching active level raise an interrupt.
// - config bit 0 enables the second interrupt pin; bit 1 is reserved.
// - watermark flag sits in bit 6 at 0x39, cleared by reading it.
// - status bits 7, 6, 5 flag X, Y, Z motion, cleared on read.
// - status bit 4 flags fifo overflow, cleared after the read.
// - status bit 2 flags rate drive ready; bits 3 and 1 reserved.
// - status bit 0 flags data ready, cleared after the read.
// - accel X, Y, Z stand as high then low byte at 59 to 64.
// - temperature high byte at 65, low byte at 66.
// - rate X at 67 and 68, rate Y high byte at 69.
// - rate codes are passed as produced, 131 codes per dps at scale 0.
// - frame-sync flag in bit 7 at 0x36, cleared by reading it.
// - watermark raised at count >= threshold, no fifo read, threshold nonzero.
`timescale 1ns/1ps
`default_nettype none
`include "motion_irq_consts.svh"
module motion_interrupt_and_output_regs #(
  parameter int PULSE_CYCLES = `PULSE_WIDTH_NS / `CLK_PERIOD_NS
) (
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_in,
  input  wire motion_irq_pkg::reg_addr_type reg_addr_in,
  input  wire logic                        reg_rd_in,
  input  wire logic                        reg_wr_in,
  input  wire motion_irq_pkg::reg_byte_type reg_wdata_in,
  output var  motion_irq_pkg::reg_byte_type reg_rdata_out,
  output var  logic                        reg_rvalid_out,
  input  wire logic                        frame_sync_pin_in,
  input  wire logic                        motion_x_event_in,
  input  wire logic                        motion_y_event_in,
  input  wire logic                        motion_z_event_in,
  input  wire logic                        overflow_event_in,
  input  wire logic                        rate_drive_ready_event_in,
  input  wire logic [9:0]                  watermark_threshold_in,
  input  wire logic [15:0]                 fifo_count_in,
  input  wire logic                        fifo_read_busy_in,
  input  wire logic                        sample_valid_in,
  input  wire motion_irq_pkg::sample_type   accel_x_sample_in,
  input  wire motion_irq_pkg::sample_type   accel_y_sample_in,
  input  wire motion_irq_pkg::sample_type   accel_z_sample_in,
  input  wire motion_irq_pkg::sample_type   temperature_sample_in,
  input  wire motion_irq_pkg::sample_type   rate_x_sample_in,
  input  wire motion_irq_pkg::reg_byte_type rate_y_high_in,
  output var  logic                        irq_ready_pin_out,
  output var  logic                        irq_ready_pin_oe_out,
  output var  logic                        second_irq_pin_out,
  output var  logic                        second_irq_pin_oe_out,
  output var  logic                        irq_active_out
);
  localparam int CNT_W = $clog2(PULSE_CYCLES + 1);

  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535) begin : g_bad_pulse
    $error("PULSE_CYCLES out of range");
  end

  // configuration
  motion_irq_pkg::reg_byte_type cfg_ff;
  logic                         cfg_active_low;
  logic                         cfg_open_drain;
  logic                         cfg_latch;
  logic                         cfg_any_read_clear;
  logic                         cfg_fs_polarity;
  logic                         cfg_fs_enable;
  logic                         cfg_second_pin;

  assign cfg_active_low     = cfg_ff[`CFG_ACTIVE_LOW_BIT];
  assign cfg_open_drain     = cfg_ff[`CFG_OPEN_DRAIN_BIT];
  assign cfg_latch          = cfg_ff[`CFG_LATCH_BIT];
  assign cfg_any_read_clear = cfg_ff[`CFG_ANY_READ_CLEAR_BIT];
  assign cfg_fs_polarity    = cfg_ff[`CFG_FS_POLARITY_BIT];
  assign cfg_fs_enable      = cfg_ff[`CFG_FS_IRQ_ENABLE_BIT];
  assign cfg_second_pin     = cfg_ff[`CFG_SECOND_PIN_BIT];

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cfg_ff <= `CFG_RESET;
    end else if (reg_wr_in && reg_addr_in == `ADDR_PIN_CONFIG) begin
      // reserved bit never stores, so it reads zero
      cfg_ff <= reg_wdata_in & `CFG_WRITE_MASK;
    end
  end

  // frame-sync pin: two flops before any logic looks at it
  logic fs_meta_ff;
  logic fs_sync_ff;
  logic fs_active_prev_ff;
  logic fs_active;
  logic fs_event;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fs_meta_ff <= 1'b0;
      fs_sync_ff <= 1'b0;
    end else begin
      fs_meta_ff <= frame_sync_pin_in;
      fs_sync_ff <= fs_meta_ff;
    end
  end

  assign fs_active = fs_sync_ff ^ cfg_fs_polarity;
  // a polarity change while the pin is steady counts as a transition
  assign fs_event  = cfg_fs_enable & fs_active & ~fs_active_prev_ff;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fs_active_prev_ff <= 1'b1;
    end else begin
      fs_active_prev_ff <= fs_active;
    end
  end

  // watermark: edge of the level condition, so a standing level does not retrigger
  logic wm_cond;
  logic wm_cond_prev_ff;
  logic wm_event;

  assign wm_cond = (watermark_threshold_in != `THRESHOLD_DISABLED)
                 && (fifo_count_in >= {6'h00, watermark_threshold_in})
                 && !fifo_read_busy_in;
  assign wm_event = wm_cond & ~wm_cond_prev_ff;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wm_cond_prev_ff <= 1'b0;
    end else begin
      wm_cond_prev_ff <= wm_cond;
    end
  end

  // status flags and their clears
  logic [`FLAG_COUNT-1:0] flag_set;
  logic [`FLAG_COUNT-1:0] flag_clr;
  logic [`FLAG_COUNT-1:0] flag_q;
  logic                   rd_any;
  logic                   clr_status;
  logic                   clr_watermark;
  logic                   clr_frame_sync;

  assign rd_any         = reg_rd_in & cfg_any_read_clear;
  assign clr_status     = reg_rd_in & (rd_any | (reg_addr_in == `ADDR_IRQ_STATUS));
  assign clr_watermark  = reg_rd_in & (rd_any | (reg_addr_in == `ADDR_WATERMARK_STATUS));
  assign clr_frame_sync = reg_rd_in & (rd_any | (reg_addr_in == `ADDR_FRAME_SYNC_STATUS));

  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[`FLAG_MOTION_X]    = motion_x_event_in;
    flag_set[`FLAG_MOTION_Y]    = motion_y_event_in;
    flag_set[`FLAG_MOTION_Z]    = motion_z_event_in;
    flag_set[`FLAG_OVERFLOW]    = overflow_event_in;
    flag_set[`FLAG_DRIVE_READY] = rate_drive_ready_event_in;
    flag_set[`FLAG_DATA_READY]  = sample_valid_in;
    flag_set[`FLAG_WATERMARK]   = wm_event;
    flag_set[`FLAG_FRAME_SYNC]  = fs_event;
    flag_clr[`FLAG_MOTION_X]    = clr_status;
    flag_clr[`FLAG_MOTION_Y]    = clr_status;
    flag_clr[`FLAG_MOTION_Z]    = clr_status;
    flag_clr[`FLAG_OVERFLOW]    = clr_status;
    flag_clr[`FLAG_DRIVE_READY] = clr_status;
    flag_clr[`FLAG_DATA_READY]  = clr_status;
    flag_clr[`FLAG_WATERMARK]   = clr_watermark;
    flag_clr[`FLAG_FRAME_SYNC]  = clr_frame_sync;
  end

  for (genvar i = 0; i < `FLAG_COUNT; i++) begin : g_flag
    status_flag_cell u_flag (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .set_in     (flag_set[i]),
      .clear_in   (flag_clr[i]),
      .flag_out   (flag_q[i])
    );
  end

  // sample registers, both bytes of one sample land together
  motion_irq_pkg::sample_type   accel_x_ff;
  motion_irq_pkg::sample_type   accel_y_ff;
  motion_irq_pkg::sample_type   accel_z_ff;
  motion_irq_pkg::sample_type   temperature_ff;
  motion_irq_pkg::sample_type   rate_x_ff;
  motion_irq_pkg::reg_byte_type rate_y_high_ff;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      accel_x_ff     <= `SAMPLE_RESET;
      accel_y_ff     <= `SAMPLE_RESET;
      accel_z_ff     <= `SAMPLE_RESET;
      temperature_ff <= `SAMPLE_RESET;
      rate_x_ff      <= `SAMPLE_RESET;
      rate_y_high_ff <= `BYTE_ZERO;
    end else if (sample_valid_in) begin
      // no bursting guard here: the host must read a pair without a sample between
      accel_x_ff     <= accel_x_sample_in;
      accel_y_ff     <= accel_y_sample_in;
      accel_z_ff     <= accel_z_sample_in;
      temperature_ff <= temperature_sample_in;
      rate_x_ff      <= rate_x_sample_in;
      rate_y_high_ff <= rate_y_high_in;
    end
  end

  // read path, answer one cycle after the strobe
  motion_irq_pkg::reg_byte_type status_byte;
  motion_irq_pkg::reg_byte_type wm_byte;
  motion_irq_pkg::reg_byte_type fs_byte;
  motion_irq_pkg::reg_byte_type rd_value;

  always_comb begin
    status_byte = `BYTE_ZERO;
    wm_byte     = `BYTE_ZERO;
    fs_byte     = `BYTE_ZERO;
    status_byte[`STAT_MOTION_X_BIT]    = flag_q[`FLAG_MOTION_X];
    status_byte[`STAT_MOTION_Y_BIT]    = flag_q[`FLAG_MOTION_Y];
    status_byte[`STAT_MOTION_Z_BIT]    = flag_q[`FLAG_MOTION_Z];
    status_byte[`STAT_OVERFLOW_BIT]    = flag_q[`FLAG_OVERFLOW];
    status_byte[`STAT_DRIVE_READY_BIT] = flag_q[`FLAG_DRIVE_READY];
    status_byte[`STAT_DATA_READY_BIT]  = flag_q[`FLAG_DATA_READY];
    wm_byte[`STAT_WATERMARK_BIT]       = flag_q[`FLAG_WATERMARK];
    fs_byte[`STAT_FRAME_SYNC_BIT]      = flag_q[`FLAG_FRAME_SYNC];
  end

  always_comb begin
    unique case (reg_addr_in)
      `ADDR_FRAME_SYNC_STATUS: rd_value = fs_byte;
      `ADDR_PIN_CONFIG:        rd_value = cfg_ff;
      `ADDR_WATERMARK_STATUS:  rd_value = wm_byte;
      `ADDR_IRQ_STATUS:        rd_value = status_byte;
      `ADDR_ACCEL_X_HIGH:      rd_value = accel_x_ff[15:8];
      `ADDR_ACCEL_X_LOW:       rd_value = accel_x_ff[7:0];
      `ADDR_ACCEL_Y_HIGH:      rd_value = accel_y_ff[15:8];
      `ADDR_ACCEL_Y_LOW:       rd_value = accel_y_ff[7:0];
      `ADDR_ACCEL_Z_HIGH:      rd_value = accel_z_ff[15:8];
      `ADDR_ACCEL_Z_LOW:       rd_value = accel_z_ff[7:0];
      `ADDR_TEMPERATURE_HIGH:  rd_value = temperature_ff[15:8];
      `ADDR_TEMPERATURE_LOW:   rd_value = temperature_ff[7:0];
      `ADDR_RATE_X_HIGH:       rd_value = rate_x_ff[15:8];
      `ADDR_RATE_X_LOW:        rd_value = rate_x_ff[7:0];
      `ADDR_RATE_Y_HIGH:       rd_value = rate_y_high_ff;
      default:                 rd_value = `BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out  <= `BYTE_ZERO;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        // value before the clear of this read is returned
        reg_rdata_out <= rd_value;
      end
    end
  end

  // interrupt pin sequencing
  motion_irq_pkg::irq_state_type state_ff;
  logic [CNT_W-1:0]              pulse_cnt_ff;
  logic                          raise;
  logic                          any_flag;

  assign raise    = |flag_set;
  assign any_flag = |flag_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_ff     <= motion_irq_pkg::IRQ_IDLE;
      pulse_cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        motion_irq_pkg::IRQ_IDLE: begin
          if (raise && cfg_latch) begin
            state_ff <= motion_irq_pkg::IRQ_LATCH;
          end else if (raise) begin
            state_ff     <= motion_irq_pkg::IRQ_PULSE;
            pulse_cnt_ff <= CNT_W'(PULSE_CYCLES - 1);
          end
        end
        motion_irq_pkg::IRQ_PULSE: begin
          // new events during a pulse merge into it, no restart
          if (pulse_cnt_ff == '0) begin
            state_ff <= motion_irq_pkg::IRQ_IDLE;
          end else begin
            pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
          end
        end
        motion_irq_pkg::IRQ_LATCH: begin
          if (!cfg_latch || (!any_flag && !raise)) begin
            state_ff <= motion_irq_pkg::IRQ_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_active_out <= 1'b0;
    end else begin
      irq_active_out <= (state_ff != motion_irq_pkg::IRQ_IDLE);
    end
  end

  // pins
  pin_drive_if main_pin ();
  pin_drive_if second_pin ();

  irq_pin_driver u_main_pin (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .assert_in     (irq_active_out),
    .active_low_in (cfg_active_low),
    .open_drain_in (cfg_open_drain),
    .enable_in     (1'b1),
    .pin           (main_pin.drv)
  );

  irq_pin_driver u_second_pin (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .assert_in     (irq_active_out),
    .active_low_in (cfg_active_low),
    .open_drain_in (cfg_open_drain),
    .enable_in     (cfg_second_pin),
    .pin           (second_pin.drv)
  );

  assign irq_ready_pin_out     = main_pin.level;
  assign irq_ready_pin_oe_out  = main_pin.oe;
  assign second_irq_pin_out    = second_pin.level;
  assign second_irq_pin_oe_out = second_pin.oe;

endmodule : motion_interrupt_and_output_regs
`default_nettype wire

// file: host_irq_model.sv
// host side of the two interrupt wires, with the board pull-ups
`timescale 1ns/1ps
`default_nettype none
module host_irq_model (
  input  wire logic pin_level_in,
  input  wire logic pin_oe_in,
  input  wire logic second_level_in,
  input  wire logic second_oe_in,
  output var  logic pin_wire_out,
  output var  logic second_wire_out
);
  // a released wire floats to the pull-up, so an idle active-low open-drain pin reads high
  always_comb pin_wire_out = pin_oe_in ? pin_level_in : 1'h1;
  always_comb second_wire_out = second_oe_in ? second_level_in : 1'h1;
endmodule : host_irq_model
`default_nettype wire

// file: motion_irq_sva.sv
// concurrent checks on the interrupt and output register block ports
`timescale 1ns/1ps
`default_nettype none
`include "motion_irq_consts.svh"
module motion_irq_sva #(
  parameter int PULSE_CYCLES = 8
) (
  input wire logic                         clk_sys_in,
  input wire logic                         rst_in,
  input wire motion_irq_pkg::reg_addr_type reg_addr_in,
  input wire logic                         reg_rd_in,
  input wire logic                         reg_wr_in,
  input wire motion_irq_pkg::reg_byte_type reg_wdata_in,
  input wire motion_irq_pkg::reg_byte_type reg_rdata_out,
  input wire logic                         reg_rvalid_out,
  input wire logic                         motion_x_event_in,
  input wire logic                         sample_valid_in,
  input wire logic [9:0]                   watermark_threshold_in,
  input wire logic [15:0]                  fifo_count_in,
  input wire logic                         fifo_read_busy_in,
  input wire logic                         irq_ready_pin_out,
  input wire logic                         irq_ready_pin_oe_out,
  input wire logic                         second_irq_pin_out,
  input wire logic                         second_irq_pin_oe_out,
  input wire logic                         irq_active_out
);
  logic [7:0]  cfg_ff;
  logic [15:0] hi_cnt_ff;
  logic        wm_cond;
  assign wm_cond = (watermark_threshold_in != 10'h000) && !fifo_read_busy_in
                   && (fifo_count_in >= {6'h00, watermark_threshold_in});
  // shadow of the pin config, the checker cannot see the register itself
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cfg_ff <= `CFG_RESET;
    end else if (reg_wr_in && reg_addr_in == `ADDR_PIN_CONFIG) begin
      cfg_ff <= reg_wdata_in & `CFG_WRITE_MASK;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    hi_cnt_ff <= (rst_in || !irq_active_out) ? 16'h0000 : hi_cnt_ff + 16'h0001;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  unmapped_read_a: assert property (reg_rd_in && reg_addr_in == 7'h46
    |=> reg_rvalid_out && reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  reserved_bit_a: assert property (reg_rd_in && reg_addr_in == `ADDR_PIN_CONFIG
    |=> reg_rdata_out[1] == 1'h0) else $error("reserved config bit reads one");
  active_level_a: assert property (!$past(rst_in) && !$past(cfg_ff[6]) |->
    irq_ready_pin_oe_out && irq_ready_pin_out == ($past(irq_active_out) ^ $past(cfg_ff[7])))
    else $error("push-pull pin level wrong");
  open_drain_a: assert property ($past(cfg_ff[6]) |-> !irq_ready_pin_out &&
    irq_ready_pin_oe_out == !($past(irq_active_out) ^ $past(cfg_ff[7])))
    else $error("open-drain pin drive wrong");
  second_off_a: assert property (!$past(cfg_ff[0]) |-> !second_irq_pin_oe_out)
    else $error("second pin driven while disabled");
  second_same_a: assert property ($past(cfg_ff[0]) |-> second_irq_pin_out ==
    irq_ready_pin_out && second_irq_pin_oe_out == irq_ready_pin_oe_out)
    else $error("second pin differs from main pin");
  pulse_width_a: assert property (!cfg_ff[5] |-> hi_cnt_ff <= PULSE_CYCLES &&
    (!$fell(irq_active_out) || hi_cnt_ff == PULSE_CYCLES)) else $error("pulse width wrong");
  latch_hold_a: assert property (cfg_ff[5] && $past(cfg_ff[5], 4) &&
    $fell(irq_active_out) |-> $past(reg_rd_in, 2) || $past(reg_rd_in, 3) ||
    $past(reg_rd_in, 4)) else $error("latched interrupt dropped without a read");
  event_irq_a: assert property ((motion_x_event_in || sample_valid_in)
    && !irq_active_out |-> ##2 irq_active_out) else $error("event raised no interrupt");
  watermark_irq_a: assert property ($rose(wm_cond) && !irq_active_out
    |-> ##[2:3] irq_active_out) else $error("watermark raised no interrupt");
endmodule : motion_irq_sva
bind motion_interrupt_and_output_regs motion_irq_sva #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.*);
`default_nettype wire

// file: motion_interrupt_and_output_regs_tb.sv
// self-checking bench for the interrupt and output register block
`timescale 1ns/1ps
`default_nettype none
`include "motion_irq_consts.svh"
module motion_interrupt_and_output_regs_tb;
  localparam logic [87:0] CAP = 88'h123456789ABCDEF00F1E2D;
  logic                         clk_sys_in, rst_in, rd, wr, fs, busy;
  logic [5:0]                   ev;
  logic [87:0]                  smp;
  logic [9:0]                   thr;
  logic [15:0]                  cnt;
  motion_irq_pkg::reg_addr_type addr;
  motion_irq_pkg::reg_byte_type wdata, rdata;
  logic                         rvalid, pin, pin_oe, p2, p2_oe, pin_w, p2_w;
  int                           bad_count = 0;
  int                           comparisons = 0;
  motion_interrupt_and_output_regs #(.PULSE_CYCLES(8)) DUT (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_rd_in(rd),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .frame_sync_pin_in(fs), .motion_x_event_in(ev[4]), .motion_y_event_in(ev[3]),
    .motion_z_event_in(ev[2]), .overflow_event_in(ev[1]), .rate_drive_ready_event_in(ev[0]),
    .watermark_threshold_in(thr), .fifo_count_in(cnt), .fifo_read_busy_in(busy),
    .sample_valid_in(ev[5]), .accel_x_sample_in(smp[87:72]), .accel_y_sample_in(smp[71:56]),
    .accel_z_sample_in(smp[55:40]), .temperature_sample_in(smp[39:24]),
    .rate_x_sample_in(smp[23:8]), .rate_y_high_in(smp[7:0]), .irq_ready_pin_out(pin),
    .irq_ready_pin_oe_out(pin_oe), .second_irq_pin_out(p2), .second_irq_pin_oe_out(p2_oe),
    .irq_active_out()
  );
  host_irq_model host (.pin_level_in(pin), .pin_oe_in(pin_oe), .second_level_in(p2),
    .second_oe_in(p2_oe), .pin_wire_out(pin_w), .second_wire_out(p2_w));
  initial begin
    clk_sys_in = 1'h0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // strobe for one cycle, the answer stands one cycle later
  task automatic rd_reg(input motion_irq_pkg::reg_addr_type a,
                        input motion_irq_pkg::reg_byte_type exp);
    @(posedge clk_sys_in);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk_sys_in);
    rd <= 1'h0;
    #1;
    check("read valid", 16'h0001, {15'h0000, rvalid});
    check("read data", {8'h00, exp}, {8'h00, rdata});
    @(posedge clk_sys_in);
  endtask : rd_reg
  task automatic wr_reg(input motion_irq_pkg::reg_addr_type a,
                        input motion_irq_pkg::reg_byte_type d);
    @(posedge clk_sys_in);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_in);
    wr <= 1'h0;
  endtask : wr_reg
  // bits: sample valid, motion x, y, z, overflow, drive ready
  task automatic fire(input logic [5:0] m);
    @(posedge clk_sys_in);
    ev <= m;
    @(posedge clk_sys_in);
    ev <= 6'h00;
  endtask : fire
  task automatic settle();
    repeat (5) @(posedge clk_sys_in);
  endtask : settle
  task automatic wait_wire(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end while (pin_w !== lvl && n < 40);
    check("pin wire", {15'h0000, lvl}, {15'h0000, pin_w});
    if (pin_w !== lvl) stop_test();
  endtask : wait_wire
  initial begin
    rst_in = 1'h1; rd = 1'h0; wr = 1'h0; fs = 1'h0; busy = 1'h0; ev = 6'h00; smp = CAP;
    thr = 10'h000; cnt = 16'h0000; addr = 7'h00; wdata = 8'h00;
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    rd_reg(`ADDR_PIN_CONFIG, `CFG_RESET);
    wr_reg(`ADDR_PIN_CONFIG, 8'hFA);
    rd_reg(`ADDR_PIN_CONFIG, 8'hF8);
    wr_reg(`ADDR_PIN_CONFIG, 8'h00);
    rd_reg(7'h46, 8'h00);
    fire(6'h20);
    smp <= 88'h0; // the capture must hold once the live samples move
    wr_reg(`ADDR_ACCEL_X_HIGH, 8'h55);
    for (int i = 0; i < 11; i++) begin
      rd_reg(7'(`ADDR_ACCEL_X_HIGH + i), CAP[87 - 8 * i -: 8]);
    end
    rd_reg(`ADDR_IRQ_STATUS, 8'h01);
    rd_reg(`ADDR_IRQ_STATUS, 8'h00);
    fire(6'h1F);
    rd_reg(`ADDR_IRQ_STATUS, 8'hF4);
    rd_reg(`ADDR_IRQ_STATUS, 8'h00);
    fire(6'h10);
    rd_reg(`ADDR_WATERMARK_STATUS, 8'h00);
    rd_reg(`ADDR_IRQ_STATUS, 8'h80);
    wr_reg(`ADDR_PIN_CONFIG, 8'h10);
    fire(6'h01);
    rd_reg(`ADDR_ACCEL_X_HIGH, 8'h12);
    rd_reg(`ADDR_IRQ_STATUS, 8'h00);
    wr_reg(`ADDR_PIN_CONFIG, 8'h00);
    @(posedge clk_sys_in);
    thr <= 10'h00A;
    cnt <= 16'h000A; // count equal to threshold is the end point
    busy <= 1'h1;
    settle();
    rd_reg(`ADDR_WATERMARK_STATUS, 8'h00);
    busy <= 1'h0;
    settle();
    rd_reg(`ADDR_WATERMARK_STATUS, 8'h40);
    rd_reg(`ADDR_WATERMARK_STATUS, 8'h00);
    thr <= 10'h000;
    busy <= 1'h1;
    settle();
    busy <= 1'h0;
    settle();
    rd_reg(`ADDR_WATERMARK_STATUS, 8'h00);
    fs <= 1'h1;
    settle();
    rd_reg(`ADDR_FRAME_SYNC_STATUS, 8'h00);
    fs <= 1'h0;
    wr_reg(`ADDR_PIN_CONFIG, 8'h04);
    fs <= 1'h1;
    settle();
    rd_reg(`ADDR_FRAME_SYNC_STATUS, 8'h80);
    rd_reg(`ADDR_FRAME_SYNC_STATUS, 8'h00);
    wr_reg(`ADDR_PIN_CONFIG, 8'h0C);
    settle();
    rd_reg(`ADDR_FRAME_SYNC_STATUS, 8'h00);
    fs <= 1'h0;
    settle();
    rd_reg(`ADDR_FRAME_SYNC_STATUS, 8'h80);
    wr_reg(`ADDR_PIN_CONFIG, 8'h20);
    settle();
    fire(6'h10);
    wait_wire(1'h1);
    rd_reg(`ADDR_IRQ_STATUS, 8'h80);
    wait_wire(1'h0);
    wr_reg(`ADDR_PIN_CONFIG, 8'hE1);
    settle();
    wait_wire(1'h1);
    fire(6'h02);
    wait_wire(1'h0);
    check("second wire", 16'h0000, {15'h0000, p2_w});
    rd_reg(`ADDR_IRQ_STATUS, 8'h10);
    wait_wire(1'h1);
    wr_reg(`ADDR_PIN_CONFIG, 8'h80);
    settle();
    fire(6'h01);
    wait_wire(1'h0);
    wait_wire(1'h1);
    rd_reg(`ADDR_IRQ_STATUS, 8'h04);
    stop_test();
  end
endmodule : motion_interrupt_and_output_regs_tb
`default_nettype wire
